/* File: rtl/obfm_pkg.sv */
package obfm_pkg;

    // register map, word addresses on the bus
    localparam logic [3:0] ADDR_FLAG_SELECT = 4'hd;   // page 8 selector
    localparam logic [3:0] ADDR_PAGE        = 4'h0;   // page select register
    localparam logic [3:0] ADDR_STATUS      = 4'h1;   // fifo fill level
    localparam logic [7:0] PAGE_FLAG        = 8'h08;
    localparam logic [7:0] FLAG_SELECT_RST  = 8'h00;
    localparam logic [7:0] PAGE_RST         = 8'h00;
    localparam int         SEL_LSB          = 0;
    localparam int         SEL_MSB          = 3;
    localparam int         DATA_BIT         = 5;
    localparam int         WORD_W           = 16;
    localparam int         FIFO_DEPTH       = 8;
    localparam int         PAR_WIDE         = 21;
    localparam int         PAR_NARROW       = 14;

    // selector codes for output bit five
    typedef enum logic [3:0] {
        OBFM_SEL_NORMAL = 4'b0000,
        OBFM_SEL_CB0    = 4'b0001,
        OBFM_SEL_CB4    = 4'b0101,
        OBFM_SEL_RED    = 4'b0110,
        OBFM_SEL_GREEN  = 4'b0111,
        OBFM_SEL_BLUE   = 4'b1000,
        OBFM_SEL_PARITY = 4'b1001,
        OBFM_SEL_PING   = 4'b1010,
        OBFM_SEL_LINE_L = 4'b1011,
        OBFM_SEL_LINE_H = 4'b1100,
        OBFM_SEL_BLACK  = 4'b1101,
        OBFM_SEL_WHITE  = 4'b1110,
        OBFM_SEL_CLAMP  = 4'b1111
    } obfm_sel_t;

    typedef enum logic [1:0] {
        OBFM_CH_RED   = 2'b00,
        OBFM_CH_GREEN = 2'b01,
        OBFM_CH_BLUE  = 2'b10
    } obfm_chan_t;

    // one pixel with every per-pixel tag it carries
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [4:0]        legacy_control_bit;
        obfm_chan_t        channel;
        logic              ping;
        logic [1:0]        line_index;
        logic              black_loop;
        logic              white_loop;
        logic              input_clamp_switch;
        logic [4:0]        extra_bits;
    } obfm_pixel_t;

    localparam int PIXEL_W = $bits(obfm_pixel_t);

    // output word: data with bit five substituted, plus lane extras
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [4:0]        extra_bits;
    } obfm_word_t;

    localparam int OUT_W = $bits(obfm_word_t);

endpackage

/* File: rtl/obfm_fifo.sv */
`timescale 1ns/1ps
module obfm_fifo
    import obfm_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } obfm_fifo_state_t;

    obfm_fifo_state_t st;
    obfm_fifo_state_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // honest full and empty straight from the count
    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[st.rd_ptr];
    assign level     = st.count;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH-1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH-1)) ? '0 : st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage has no reset, only written words are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st.wr_ptr] <= in_data;
        end
    end

endmodule

/* File: rtl/obfm_flag_select.sv */
`timescale 1ns/1ps
module obfm_flag_select
    import obfm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        advance,
    input  wire obfm_pixel_t pixel,
    input  wire obfm_sel_t   sel,
    input  wire logic        first_serial_lane,
    output obfm_word_t       word
);
    // parity over the low 21 or 14 bits of data and extras
    function automatic logic lane_parity(input obfm_pixel_t p, input logic wide);
        logic [PAR_WIDE-1:0] bits;
        logic [PAR_WIDE-1:0] mask;
        bits = {p.extra_bits, p.data};
        mask = wide ? {PAR_WIDE{1'b1}} : PAR_WIDE'((1 << PAR_NARROW) - 1);
        return ^(bits & mask);
    endfunction

    obfm_word_t st;
    obfm_word_t next_st;
    logic       flag;

    assign word = st;

    // choose the bit that stands in for data bit five
    always_comb begin
        flag = pixel.data[DATA_BIT];                               // [R1]
        case (sel)
            OBFM_SEL_NORMAL: flag = pixel.data[DATA_BIT];          // [R1]
            OBFM_SEL_RED:    flag = (pixel.channel == OBFM_CH_RED);   // [R3]
            OBFM_SEL_GREEN:  flag = (pixel.channel == OBFM_CH_GREEN); // [R3]
            OBFM_SEL_BLUE:   flag = (pixel.channel == OBFM_CH_BLUE);  // [R3]
            OBFM_SEL_PARITY: flag = lane_parity(pixel, first_serial_lane); // [R4]
            OBFM_SEL_PING:   flag = pixel.ping;                    // [R5]
            OBFM_SEL_LINE_L: flag = pixel.line_index[0];           // [R6]
            OBFM_SEL_LINE_H: flag = pixel.line_index[1];           // [R6]
            OBFM_SEL_BLACK:  flag = pixel.black_loop;              // [R7]
            OBFM_SEL_WHITE:  flag = pixel.white_loop;              // [R8]
            OBFM_SEL_CLAMP:  flag = pixel.input_clamp_switch;      // [R9]
            default: begin
                // codes one to five pick legacy control bits zero to four
                flag = pixel.legacy_control_bit[3'(sel - OBFM_SEL_CB0)]; // [R2]
            end
        endcase
    end

    // flag and its own pixel word leave in the same register stage
    always_comb begin
        next_st = st;
        if (advance) begin
            next_st.data             = pixel.data;
            next_st.data[DATA_BIT]   = flag;                       // [R11]
            next_st.extra_bits       = pixel.extra_bits;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

/* File: rtl/obfm_top.sv */
// How it works
// R1: code zero passes normal data bit five
// R2: codes one-five give legacy control bits
// R3: codes six-eight flag red, green, blue
// R4: code nine gives parity, 21/14 bits
// R5: code ten high for ping path
// R6: codes eleven, twelve give line index bits
// R7: code thirteen flags black loop pixels
// R8: code fourteen flags white loop pixels
// R9: code fifteen flags closed clamp switch
// R10: selector in page 8 reg 13, resets zero
// R11: flag aligned with its own pixel word
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module obfm_top
    import obfm_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    // avalon-mm slave
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    output logic [1:0]         avs_response,
    // pixel stream in from the conversion path
    input  wire logic          pix_valid,
    output logic               pix_ready,
    input  wire obfm_pixel_t   pix_in,
    input  wire logic          first_serial_lane,
    // pixel words out to the receiver
    output logic               out_valid,
    input  wire logic          out_ready,
    output obfm_word_t         out_word
);
    localparam logic [1:0] RESP_OK     = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;
    localparam int         LVL_W       = $clog2(FIFO_DEPTH) + 1;

    typedef enum logic [1:0] {
        OBFM_BUS_IDLE = 2'b00,
        OBFM_BUS_DONE = 2'b01
    } obfm_bus_t;

    // bus, register and pixel stage state
    typedef struct packed {
        obfm_bus_t   bus;
        logic [7:0]  page;
        logic [7:0]  flag_select;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic        stage_valid;
    } obfm_top_state_t;

    obfm_top_state_t st;
    obfm_top_state_t next_st;
    logic [1:0]      rst_sync;
    logic            rst_n;
    logic            stage_adv;
    logic            fifo_in_ready;
    logic [LVL_W-1:0] fifo_level;
    obfm_word_t      fifo_word;
    obfm_word_t      stage_word;
    logic [OUT_W-1:0] fifo_out;
    logic            first_lane_q1;
    logic            first_lane_q2;

    // address decode shared by read and write paths
    function automatic logic [1:0] reg_hit(input logic [3:0] a, input logic [7:0] pg);
        if (a == ADDR_PAGE) begin
            return 2'd1;
        end else if (a == ADDR_STATUS) begin
            return 2'd2;
        end else if (a == ADDR_FLAG_SELECT && pg == PAGE_FLAG) begin
            return 2'd3;
        end else begin
            return 2'd0;
        end
    endfunction

    // reset: asynchronous assert, two-flop release
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= '0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // lane enable is a pin, so it is synchronised before use
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_lane_q1 <= 1'b0;
            first_lane_q2 <= 1'b0;
        end else begin
            first_lane_q1 <= first_serial_lane;
            first_lane_q2 <= first_lane_q1;
        end
    end

    // pixel stage advances when empty or when the fifo takes its word
    assign stage_adv = pix_valid & (~st.stage_valid | fifo_in_ready);
    assign pix_ready = ~st.stage_valid | fifo_in_ready;

    obfm_flag_select u_sel (
        .sys_clk           (sys_clk),
        .rst_n             (rst_n),
        .advance           (stage_adv),
        .pixel             (pix_in),
        .sel               (obfm_sel_t'(st.flag_select[SEL_MSB:SEL_LSB])),
        .first_serial_lane (first_lane_q2),
        .word              (stage_word)
    );

    // back-pressure from the receiver reaches the pixel source via the fifo
    obfm_fifo #(
        .WIDTH (OUT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (st.stage_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (stage_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );
    assign fifo_word = obfm_word_t'(fifo_out);
    assign out_word  = fifo_word;

    // bus answers one cycle after the request is seen
    assign avs_waitrequest = (avs_read | avs_write) & (st.bus == OBFM_BUS_IDLE);
    assign avs_readdata    = st.rdata;
    assign avs_response    = st.resp;

    // next-state logic for bus slave, registers and pixel stage
    always_comb begin
        next_st = st;
        if (stage_adv) begin
            next_st.stage_valid = 1'b1;
        end else if (fifo_in_ready) begin
            next_st.stage_valid = 1'b0;
        end
        case (st.bus)
            OBFM_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_st.bus   = OBFM_BUS_DONE;
                    next_st.rdata = '0;
                    next_st.resp  = RESP_OK;
                    case (reg_hit(avs_address, st.page))
                        2'd1: begin
                            if (avs_write && avs_byteenable[0]) begin
                                next_st.page = avs_writedata[7:0];
                            end
                            next_st.rdata[7:0] = st.page;
                        end
                        2'd2: begin
                            next_st.rdata[LVL_W-1:0] = fifo_level;
                        end
                        2'd3: begin
                            // only the low nibble is kept, upper bits read zero
                            if (avs_write && avs_byteenable[0]) begin
                                next_st.flag_select = {4'h0,
                                    avs_writedata[SEL_MSB:SEL_LSB]};   // [R10]
                            end
                            next_st.rdata[7:0] = st.flag_select;
                        end
                        default: begin
                            next_st.resp = RESP_DECERR;
                        end
                    endcase
                end
            end
            OBFM_BUS_DONE: begin
                next_st.bus = OBFM_BUS_IDLE;
            end
            default: begin
                next_st.bus = OBFM_BUS_IDLE;
            end
        endcase
    end

    // selector resets to normal data output
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st.bus         <= OBFM_BUS_IDLE;
            st.page        <= PAGE_RST;
            st.flag_select <= FLAG_SELECT_RST;                         // [R10]
            st.rdata       <= '0;
            st.resp        <= RESP_OK;
            st.stage_valid <= 1'b0;
        end else begin
            st.bus         <= next_st.bus;
            st.page        <= next_st.page;
            st.flag_select <= next_st.flag_select;
            st.rdata       <= next_st.rdata;
            st.resp        <= next_st.resp;
            st.stage_valid <= next_st.stage_valid;
        end
    end

endmodule

/* File: dv/obfm_top_props.sv */
`timescale 1ns/1ps
module obfm_top_props
    import obfm_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic        pix_valid,
    input wire logic        pix_ready,
    input wire obfm_pixel_t pix_in,
    input wire logic        first_serial_lane,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire obfm_word_t  out_word
);
    logic [7:0] page_q;
    logic [3:0] sel_q;
    logic       done;
    logic       sel_map;
    logic       unmap;

    // decode seen from the bus side only
    assign done    = (avs_read || avs_write) && !avs_waitrequest;
    assign sel_map = avs_address == ADDR_FLAG_SELECT && page_q == PAGE_FLAG;
    assign unmap   = avs_address != ADDR_PAGE && avs_address != ADDR_STATUS && !sel_map;

    // shadow copies of the writable registers, updated on accepted writes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            page_q <= PAGE_RST;
            sel_q  <= FLAG_SELECT_RST[3:0];
        end else if (done && avs_write && avs_byteenable[0]) begin
            if (avs_address == ADDR_PAGE)
                page_q <= avs_writedata[7:0];
            if (sel_map)
                sel_q <= avs_writedata[3:0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd_done;
        avs_read && !avs_waitrequest;
    endsequence

    wait_one_a: assert property (s_wait |=> !avs_waitrequest)
        else $error("bus answer late");
    unmap_resp_a: assert property (done && unmap |-> avs_response == 2'b11)
        else $error("unmapped access not flagged");
    mapped_ok_a: assert property (done && !unmap |-> avs_response == 2'b00)
        else $error("mapped access flagged");
    unmap_zero_a: assert property (s_rd_done ##0 unmap |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    sel_read_a: assert property (s_rd_done ##0 sel_map |-> avs_readdata == {28'h0, sel_q})
        else $error("selector readback wrong");
    page_read_a: assert property (s_rd_done ##0 avs_address == ADDR_PAGE
        |-> avs_readdata == {24'h0, page_q})
        else $error("page readback wrong");
    word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("output word moved while stalled");
    take_lat_a: assert property (pix_valid && pix_ready && !out_valid |-> ##2 out_valid)
        else $error("pixel word late");
endmodule

bind obfm_top obfm_top_props chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_in(pix_in), .first_serial_lane(first_serial_lane), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word));

/* File: dv/obfm_receiver.sv */
`timescale 1ns/1ps
module obfm_receiver
    import obfm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       stall,
    input  wire logic       slow,
    input  wire logic       out_valid,
    input  wire obfm_word_t out_word,
    output logic            out_ready
);
    obfm_word_t got[$];
    logic [1:0] beat;

    // slow mode accepts one cycle in four, stall accepts nothing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            beat <= 2'h0;
        else
            beat <= beat + 2'h1;
    end
    assign out_ready = !stall && (!slow || beat == 2'h0);

    // collect every word handed over
    always @(posedge sys_clk) begin
        if (rst_n && out_valid && out_ready)
            got.push_back(out_word);
    end
endmodule

/* File: dv/obfm_top_test.sv */
`timescale 1ns/1ps
module obfm_top_test;
    import obfm_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        pix_valid = 1'b0;
    logic        pix_ready;
    obfm_pixel_t pix_in = '0;
    logic        lane = 1'b1;
    logic        out_valid;
    logic        out_ready;
    obfm_word_t  out_word;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;
    obfm_word_t  exp_q[$];
    logic [31:0] rd;
    logic [1:0]  rsp;

    always #5 sys_clk = ~sys_clk;

    obfm_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_in(pix_in),
        .first_serial_lane(lane), .out_valid(out_valid), .out_ready(out_ready),
        .out_word(out_word));
    obfm_receiver rx_u (.sys_clk(sys_clk), .rst_n(reset_n), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready));

    task automatic finish_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    function automatic obfm_pixel_t mk(input int k);
        obfm_pixel_t p;
        p.data = 16'h5a3c ^ 16'(k * 16'h0b27);
        p.legacy_control_bit = 5'(k * 7);
        p.channel = obfm_chan_t'(2'(k % 3));
        p.ping = k[0];
        p.line_index = k[2:1];
        p.black_loop = k[1];
        p.white_loop = k[2];
        p.input_clamp_switch = k[0] ^ k[2];
        p.extra_bits = 5'(k * 3);
        return p;
    endfunction

    // expected word: data kept, bit five replaced per selector code
    function automatic obfm_word_t expw(input logic [3:0] c, input obfm_pixel_t p);
        obfm_word_t  w;
        logic        b;
        logic [20:0] v;
        v = {p.extra_bits, p.data};
        case (c)
            4'h0: b = p.data[5];
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5: b = p.legacy_control_bit[c - 4'h1];
            4'h6, 4'h7, 4'h8: b = p.channel == obfm_chan_t'(2'(c - 4'h6));
            4'h9: b = lane ? ^v : ^v[13:0];
            4'ha: b = p.ping;
            4'hb: b = p.line_index[0];
            4'hc: b = p.line_index[1];
            4'hd: b = p.black_loop;
            4'he: b = p.white_loop;
            default: b = p.input_clamp_switch;
        endcase
        w.data = p.data;
        w.data[5] = b;
        w.extra_bits = p.extra_bits;
        return w;
    endfunction

    // stream n pixels, valid held high between them
    task automatic send(input int n, input logic [3:0] c);
        for (int k = 0; k < n; k++) begin
            pix_valid <= 1'b1;
            pix_in <= mk(k);
            exp_q.push_back(expw(c, mk(k)));
            do @(posedge sys_clk); while (pix_ready !== 1'b1);
        end
        pix_valid <= 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (rx_u.got.size() < exp_q.size() && n < 500) begin
            @(posedge sys_clk);
            n++;
        end
        check(32'(rx_u.got.size()), 32'(exp_q.size()));
        while (exp_q.size() > 0 && rx_u.got.size() > 0)
            check(32'(rx_u.got.pop_front()), 32'(exp_q.pop_front()));
        exp_q.delete();
        rx_u.got.delete();
    endtask

    task automatic t_regs();
        bus(1'b0, ADDR_PAGE, 32'h0);
        check(rd, {24'h0, PAGE_RST});
        bus(1'b0, ADDR_FLAG_SELECT, 32'h0);
        check(32'(rsp), 32'h3);
        bus(1'b1, ADDR_PAGE, 32'(PAGE_FLAG));
        bus(1'b0, ADDR_FLAG_SELECT, 32'h0);
        check(rd, 32'(FLAG_SELECT_RST));
        bus(1'b1, ADDR_FLAG_SELECT, 32'hff);
        bus(1'b0, ADDR_FLAG_SELECT, 32'h0);
        check(rd, 32'h0000000f);
        // byte 0 disabled: the selector must keep its value
        avs_byteenable <= 4'he;
        bus(1'b1, ADDR_FLAG_SELECT, 32'h3);
        avs_byteenable <= 4'hf;
        bus(1'b0, ADDR_FLAG_SELECT, 32'h0);
        check(rd, 32'h0000000f);
        bus(1'b1, 4'h7, 32'h55);
        check(32'(rsp), 32'h3);
    endtask

    // every code, slow receiver on odd codes
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            slow <= c[0];
            bus(1'b1, ADDR_FLAG_SELECT, 32'(c));
            send(8, 4'(c));
            drain();
        end
        slow <= 1'b0;
        lane <= 1'b0;
        repeat (4) @(posedge sys_clk);
        bus(1'b1, ADDR_FLAG_SELECT, 32'h9);
        send(8, 4'h9);
        drain();
        lane <= 1'b1;
    endtask

    // fill until refused, then change selector with words queued
    task automatic t_full();
        int n;
        n = 0;
        stall <= 1'b1;
        bus(1'b1, ADDR_FLAG_SELECT, 32'h6);
        fork
            send(12, 4'h6);
            begin
                while (pix_ready !== 1'b0 && n < 40) begin
                    @(posedge sys_clk);
                    n++;
                end
                check(32'(pix_ready), 32'h0);
                bus(1'b0, ADDR_STATUS, 32'h0);
                check(32'(rd[3:0]), 32'(FIFO_DEPTH));
                stall <= 1'b0;
            end
        join
        drain();
        // last pop may share this edge, so look once the fifo has settled
        @(posedge sys_clk);
        check(32'(out_valid), 32'h0);
        stall <= 1'b1;
        send(3, 4'h6);
        bus(1'b1, ADDR_FLAG_SELECT, 32'h7);
        send(3, 4'h7);
        stall <= 1'b0;
        drain();
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_codes();
        t_full();
        finish_test();
    end
endmodule
